/* File: acd_pkg.sv */
// Package with the constants, codes and carriers of the accumulator arithmetic datapath.
// Function
// - Memory instructions take their operation code from instruction bits 0 to 4.
// - Load copies memory into accumulator; store copies accumulator into memory.
// - Double store writes both registers at even address, auxiliary only at odd.
// - Store-address replaces memory bits 7 to 19 with accumulator bits 7 to 19.
// - Add or subtract overflow sets indicator, drops top bit, reverses sign.
// - Add and subtract combine memory word into accumulator algebraically.
// - Double add sums an even word pair into accumulator and auxiliary.
// - Double subtract removes word pair; auxiliary sign follows accumulator sign.
// - Multiply memory by auxiliary, add prior accumulator to low half, clear overflow.
// - Multiply takes 12.5 word times plus quarter per multiplier one bit, rounded up.
// - Divide puts quotient in accumulator, signed remainder in auxiliary, clears overflow.
// - Divisor magnitude not above accumulator magnitude sets overflow and ends divide.
// - Divide takes 25 word times for positive, 28 for negative dividend.
// - Register instructions decode bits 0 to 4 plus bits 7 to 19.
// - Inter-register copies, swap, and move-with-clear between accumulator and auxiliary.
// - Constant loads give zero, plus one, or all ones.
// - Increment and decrement at bit 19 set overflow on capacity excess.
// - Complement inverts all bits; negate forms negative with overflow check.
// - The idle instruction changes nothing and takes 2 word times.
// - Execution times count in 20 microsecond word times including fetch.
package acd_pkg;
	localparam int WORD_W = 20;
	localparam int ADDR_W = 13;
	localparam int OPC_HI = 19;
	localparam int OPC_LO = 15;
	localparam int WORD_TIME_NS = 20000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int WORD_CYCLES = WORD_TIME_NS / CLK_PERIOD_NS;
	localparam int WT_W = 6;
	localparam logic [WT_W-1:0] WT_SHORT = 6'h02;
	localparam logic [WT_W-1:0] WT_DOUBLE = 6'h03;
	localparam logic [WT_W-1:0] WT_DIV_POS = 6'h19;
	localparam logic [WT_W-1:0] WT_DIV_NEG = 6'h1C;
	localparam logic [7:0] MPY_BASE_QTR = 8'h32;
	localparam logic [7:0] QTR_ROUND = 8'h03;
	localparam logic [4:0] OP_LOAD = 5'h00;
	localparam logic [4:0] OP_ADD = 5'h01;
	localparam logic [4:0] OP_SUB = 5'h02;
	localparam logic [4:0] OP_STORE = 5'h03;
	localparam logic [4:0] OP_DLOAD = 5'h08;
	localparam logic [4:0] OP_DADD = 5'h09;
	localparam logic [4:0] OP_DSUB = 5'h0A;
	localparam logic [4:0] OP_DSTORE = 5'h0B;
	localparam logic [4:0] OP_MPY = 5'h0D;
	localparam logic [4:0] OP_DIV = 5'h0E;
	localparam logic [4:0] OP_STADDR = 5'h17;
	localparam logic [19:0] REG_CODE_MASK = 20'hF9FFF;
	localparam logic [19:0] RC_IDLE = 20'hA8800;
	localparam logic [19:0] RC_AUX_TO_ACC = 20'hA8801;
	localparam logic [19:0] RC_ZERO = 20'hA8802;
	localparam logic [19:0] RC_ACC_TO_AUX = 20'hA8804;
	localparam logic [19:0] RC_SWAP = 20'hA8805;
	localparam logic [19:0] RC_MOVE_CLEAR = 20'hA8806;
	localparam logic [19:0] RC_PLUS_ONE = 20'hA8812;
	localparam logic [19:0] RC_INCREMENT = 20'hA881A;
	localparam logic [19:0] RC_CHANGE_SIGN = 20'hA8820;
	localparam logic [19:0] RC_ALL_ONES = 20'hA8842;
	localparam logic [19:0] RC_DECREMENT = 20'hA884A;
	localparam logic [19:0] RC_INVERT = 20'hA894A;
	localparam logic [19:0] RC_NEGATE = 20'hA895A;
	localparam logic [19:0] WORD_ZERO = 20'h00000;
	localparam logic [19:0] WORD_ONE = 20'h00001;
	localparam logic [19:0] WORD_ONES = 20'hFFFFF;
	localparam logic [19:0] WORD_MAXNEG = 20'h80000;

	typedef enum logic [1:0] {
		ACD_ST_IDLE,
		ACD_ST_READ,
		ACD_ST_EXEC,
		ACD_ST_WAIT
	} acd_state_e;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] wdata;
	} acd_mem_req_s;
endpackage : acd_pkg

/* File: acd_datapath.sv */
// Accumulator and auxiliary register datapath with core storage access and word-time pacing.
`timescale 1ns/1ps
module acd_datapath #(
	parameter int WORD_CYCLES = acd_pkg::WORD_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic instr_valid_in,
	input wire logic [19:0] instr_in,
	input wire logic ovf_clear_in,
	input wire logic [19:0] mem_rdata_in,
	output logic instr_ready_out,
	output logic done_out,
	output acd_pkg::acd_mem_req_s mem_req_out,
	output logic [19:0] acc_out,
	output logic [19:0] aux_out,
	output logic overflow_out
);
	acd_pkg::acd_state_e state;
	acd_pkg::acd_mem_req_s mem_req;
	logic [19:0] acc;
	logic [19:0] aux;
	logic ovf;
	logic [19:0] ir;
	logic [19:0] op_hi;
	logic [19:0] op_lo;
	logic [1:0] rd_step;
	logic pend_wr;
	logic [acd_pkg::WT_W-1:0] wt;
	logic [15:0] cyc;
	logic done;
	// High in the cycle in which the memory shows the data of an earlier read.
	logic rd_valid;

	// Instruction field decode.
	wire [4:0] opc = ir[acd_pkg::OPC_HI:acd_pkg::OPC_LO];
	wire [12:0] y_addr = ir[12:0];
	wire y_odd = ir[0];
	wire [4:0] in_opc = instr_in[acd_pkg::OPC_HI:acd_pkg::OPC_LO];
	wire in_reads = (in_opc == acd_pkg::OP_LOAD) || (in_opc == acd_pkg::OP_ADD)
		|| (in_opc == acd_pkg::OP_SUB) || (in_opc == acd_pkg::OP_DLOAD)
		|| (in_opc == acd_pkg::OP_DADD) || (in_opc == acd_pkg::OP_DSUB)
		|| (in_opc == acd_pkg::OP_MPY) || (in_opc == acd_pkg::OP_DIV)
		|| (in_opc == acd_pkg::OP_STADDR);
	wire in_pair = ((in_opc == acd_pkg::OP_DLOAD) || (in_opc == acd_pkg::OP_DADD)
		|| (in_opc == acd_pkg::OP_DSUB)) && !instr_in[0];
	wire [19:0] reg_code = ir & acd_pkg::REG_CODE_MASK;
	wire is_reg = (opc == acd_pkg::RC_IDLE[19:15]);
	// A double operand at an even address reads a word pair, high word first.
	wire ir_pair = ((opc == acd_pkg::OP_DLOAD) || (opc == acd_pkg::OP_DADD)
		|| (opc == acd_pkg::OP_DSUB)) && !y_odd;

	// Single-length add and subtract with wrap-around overflow.
	wire [19:0] sum1 = acc + op_hi;
	wire [19:0] dif1 = acc - op_hi;
	wire ov_add1 = (acc[19] == op_hi[19]) && (sum1[19] != acc[19]);
	wire ov_sub1 = (acc[19] != op_hi[19]) && (dif1[19] != acc[19]);

	// Double-length operand: even pair, or the same word twice at odd address.
	wire [38:0] dacc = {acc, aux[18:0]};
	wire [19:0] low_word = y_odd ? op_hi : op_lo;
	wire [38:0] dmem = {op_hi, low_word[18:0]};
	wire [38:0] sum2 = dacc + dmem;
	wire [38:0] dif2 = dacc - dmem;
	wire ov_add2 = (dacc[38] == dmem[38]) && (sum2[38] != dacc[38]);
	wire ov_sub2 = (dacc[38] != dmem[38]) && (dif2[38] != dacc[38]);

	// Multiply with the prior accumulator added into the low half.
	wire signed [39:0] prod = $signed(op_hi) * $signed(aux);
	wire signed [39:0] addend = {{20{acc[19]}}, acc};
	wire [39:0] mres = prod + addend;
	logic [4:0] ones_cnt;
	always_comb begin
		ones_cnt = 5'h00;
		for (int i = 0; i < 19; i++) begin
			ones_cnt = ones_cnt + {4'h0, aux[i]};
		end
	end
	wire [7:0] mpy_qtr = acd_pkg::MPY_BASE_QTR + {3'h0, ones_cnt} + acd_pkg::QTR_ROUND;
	wire [acd_pkg::WT_W-1:0] mpy_wt = mpy_qtr[7:2];

	// Divide of accumulator and auxiliary magnitude bits by the memory word.
	wire signed [38:0] dividend = $signed(dacc);
	wire signed [38:0] divisor = {{19{op_hi[19]}}, op_hi};
	wire [20:0] mag_div = op_hi[19] ? (21'h00000 - {op_hi[19], op_hi}) : {1'b0, op_hi};
	wire [20:0] mag_acc = acc[19] ? (21'h00000 - {acc[19], acc}) : {1'b0, acc};
	wire div_bad = !(mag_div > mag_acc);
	// Division stands apart from the select, which would otherwise make it unsigned.
	wire signed [38:0] quot_s = dividend / divisor;
	wire signed [38:0] remd_s = dividend % divisor;
	wire [38:0] quot = div_bad ? 39'h0 : quot_s;
	wire [38:0] remd = div_bad ? 39'h0 : remd_s;
	wire [acd_pkg::WT_W-1:0] div_wt = acc[19] ? acd_pkg::WT_DIV_NEG : acd_pkg::WT_DIV_POS;

	// Register-manipulation arithmetic.
	wire [19:0] inc_val = acc + acd_pkg::WORD_ONE;
	wire [19:0] dec_val = acc - acd_pkg::WORD_ONE;
	wire [19:0] neg_val = acd_pkg::WORD_ZERO - acc;

	// Next register values chosen by the instruction in the execute step.
	logic [19:0] next_acc;
	logic [19:0] next_aux;
	logic next_ovf_set;
	logic next_ovf_clr;
	logic [acd_pkg::WT_W-1:0] next_wt;
	always_comb begin
		next_acc = acc;
		next_aux = aux;
		next_ovf_set = 1'b0;
		next_ovf_clr = 1'b0;
		next_wt = acd_pkg::WT_SHORT;
		if (is_reg) begin
			case (reg_code)
				acd_pkg::RC_AUX_TO_ACC: next_acc = aux;
				acd_pkg::RC_ACC_TO_AUX: next_aux = acc;
				acd_pkg::RC_SWAP: begin
					next_acc = aux;
					next_aux = acc;
				end
				acd_pkg::RC_MOVE_CLEAR: begin
					next_aux = acc;
					next_acc = acd_pkg::WORD_ZERO;
				end
				acd_pkg::RC_ZERO: next_acc = acd_pkg::WORD_ZERO;
				acd_pkg::RC_PLUS_ONE: next_acc = acd_pkg::WORD_ONE;
				acd_pkg::RC_ALL_ONES: next_acc = acd_pkg::WORD_ONES;
				acd_pkg::RC_INCREMENT: begin
					next_acc = inc_val;
					next_ovf_set = (inc_val == acd_pkg::WORD_MAXNEG);
				end
				acd_pkg::RC_DECREMENT: begin
					next_acc = dec_val;
					next_ovf_set = (acc == acd_pkg::WORD_MAXNEG);
				end
				acd_pkg::RC_INVERT: next_acc = ~acc;
				acd_pkg::RC_NEGATE: begin
					next_acc = neg_val;
					next_ovf_set = (acc == acd_pkg::WORD_MAXNEG);
				end
				acd_pkg::RC_CHANGE_SIGN: next_acc = {~acc[19], acc[18:0]};
				default: next_acc = acc;
			endcase
		end else begin
			case (opc)
				acd_pkg::OP_LOAD: next_acc = op_hi;
				acd_pkg::OP_ADD: begin
					next_acc = sum1;
					next_ovf_set = ov_add1;
				end
				acd_pkg::OP_SUB: begin
					next_acc = dif1;
					next_ovf_set = ov_sub1;
				end
				acd_pkg::OP_DLOAD: begin
					next_wt = acd_pkg::WT_DOUBLE;
					if (y_odd) begin
						next_aux = op_hi;
					end else begin
						next_acc = op_hi;
						next_aux = op_lo;
					end
				end
				acd_pkg::OP_DADD: begin
					next_wt = acd_pkg::WT_DOUBLE;
					next_acc = sum2[38:19];
					next_aux = {sum2[38], sum2[18:0]};
					next_ovf_set = ov_add2;
				end
				acd_pkg::OP_DSUB: begin
					next_wt = acd_pkg::WT_DOUBLE;
					next_acc = dif2[38:19];
					next_aux = {dif2[38], dif2[18:0]};
					next_ovf_set = ov_sub2;
				end
				acd_pkg::OP_DSTORE: next_wt = acd_pkg::WT_DOUBLE;
				acd_pkg::OP_MPY: begin
					next_wt = mpy_wt;
					next_acc = mres[38:19];
					next_aux = {mres[38], mres[18:0]};
					next_ovf_clr = 1'b1;
				end
				acd_pkg::OP_DIV: begin
					next_ovf_clr = 1'b1;
					if (div_bad) begin
						next_ovf_set = 1'b1;
					end else begin
						next_wt = div_wt;
						next_acc = quot[19:0];
						next_aux = remd[19:0];
					end
				end
				default: next_acc = acc;
			endcase
		end
	end

	// Memory request for the execute step.
	wire exec_st = (opc == acd_pkg::OP_STORE);
	wire exec_dst = (opc == acd_pkg::OP_DSTORE);
	wire exec_sto = (opc == acd_pkg::OP_STADDR);
	wire exec_wr = !is_reg && (exec_st || exec_dst || exec_sto);
	wire [19:0] exec_wdata = exec_sto ? {op_hi[19:13], acc[12:0]}
		: (exec_dst && y_odd) ? aux : acc;
	wire [15:0] last_cyc = 16'(wt * WORD_CYCLES - 1);

	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state <= acd_pkg::ACD_ST_IDLE;
			mem_req <= '0;
			acc <= acd_pkg::WORD_ZERO;
			aux <= acd_pkg::WORD_ZERO;
			ovf <= 1'b0;
			ir <= acd_pkg::RC_IDLE;
			op_hi <= acd_pkg::WORD_ZERO;
			op_lo <= acd_pkg::WORD_ZERO;
			rd_step <= 2'h0;
			rd_valid <= 1'b0;
			pend_wr <= 1'b0;
			wt <= acd_pkg::WT_SHORT;
			cyc <= 16'h0000;
			done <= 1'b0;
		end else if (ce_in) begin
			done <= 1'b0;
			mem_req.rd <= 1'b0;
			mem_req.wr <= 1'b0;
			cyc <= cyc + 16'h0001;
			rd_valid <= mem_req.rd;
			if (ovf_clear_in && state != acd_pkg::ACD_ST_EXEC) begin
				ovf <= 1'b0;
			end
			case (state)
				acd_pkg::ACD_ST_IDLE: begin
					cyc <= 16'h0000;
					if (instr_valid_in) begin
						ir <= instr_in;
						rd_step <= in_pair ? 2'h2 : 2'h1;
						mem_req.rd <= in_reads;
						mem_req.addr <= instr_in[12:0];
						state <= in_reads ? acd_pkg::ACD_ST_READ : acd_pkg::ACD_ST_EXEC;
					end
				end
				acd_pkg::ACD_ST_READ: begin
					// Read data stands on the bus one cycle after the request cycle.
					if (rd_step == 2'h2 && !rd_valid) begin
						mem_req.rd <= 1'b1;
						mem_req.addr <= y_addr | 13'h0001;
					end
					if (rd_valid) begin
						rd_step <= rd_step - 2'h1;
						if (rd_step == 2'h2 || !ir_pair) begin
							op_hi <= mem_rdata_in;
						end else begin
							op_lo <= mem_rdata_in;
						end
						if (rd_step == 2'h1) begin
							state <= acd_pkg::ACD_ST_EXEC;
						end
					end
				end
				acd_pkg::ACD_ST_EXEC: begin
					acc <= next_acc;
					aux <= next_aux;
					// A hardware set of the indicator wins over any clear in the same cycle.
					if (next_ovf_set) begin
						ovf <= 1'b1;
					end else if (next_ovf_clr || ovf_clear_in) begin
						ovf <= 1'b0;
					end
					wt <= next_wt;
					mem_req.wr <= exec_wr;
					mem_req.addr <= exec_dst ? (y_addr & 13'h1FFE) | {12'h000, y_odd} : y_addr;
					mem_req.wdata <= exec_wdata;
					pend_wr <= exec_dst && !y_odd && !is_reg;
					state <= acd_pkg::ACD_ST_WAIT;
				end
				acd_pkg::ACD_ST_WAIT: begin
					if (pend_wr) begin
						pend_wr <= 1'b0;
						mem_req.wr <= 1'b1;
						mem_req.addr <= y_addr | 13'h0001;
						mem_req.wdata <= aux;
					end
					// A slow operand fetch with very short word times still ends the instruction.
					if (cyc >= last_cyc) begin
						done <= 1'b1;
						state <= acd_pkg::ACD_ST_IDLE;
					end
				end
				default: state <= acd_pkg::ACD_ST_IDLE;
			endcase
		end
	end

	assign instr_ready_out = (state == acd_pkg::ACD_ST_IDLE);
	assign done_out = done;
	assign mem_req_out = mem_req;
	assign acc_out = acc;
	assign aux_out = aux;
	assign overflow_out = ovf;
endmodule : acd_datapath

/* File: acd_datapath_properties.sv */
// Concurrent checks on the ports of the accumulator arithmetic datapath.
`timescale 1ns/1ps
module acd_checker #(
	parameter int WORD_CYCLES = acd_pkg::WORD_CYCLES
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic instr_valid_in,
	input wire logic [19:0] instr_in,
	input wire logic instr_ready_out,
	input wire logic done_out,
	input wire acd_pkg::acd_mem_req_s mem_req_out,
	input wire logic [19:0] acc_out,
	input wire logic [19:0] aux_out,
	input wire logic overflow_out
);
	logic [15:0] cnt;
	logic short_op;
	wire logic take = ce_in && instr_valid_in && instr_ready_out;
	wire logic [4:0] opc = instr_in[19:15];
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (reset_in);
	sequence s_take(logic [4:0] code);
		take && opc == code;
	endsequence
	sequence s_write_acc;
		##1 mem_req_out.wr && mem_req_out.wdata == acc_out
			&& mem_req_out.addr == $past(instr_in[12:0], 2);
	endsequence
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			cnt <= 16'h0000;
			short_op <= 1'b0;
		end else if (ce_in) begin
			cnt <= take ? 16'h0000 : cnt + 16'h0001;
			if (take) begin
				short_op <= opc == acd_pkg::OP_LOAD || opc == acd_pkg::OP_STORE;
			end
		end
	end
	chk_ready_drop: assert property (take |=> !instr_ready_out)
		else $error("ready stayed high after an accept");
	chk_done_pulse: assert property (done_out && ce_in |=> !done_out)
		else $error("done lasted more than one cycle");
	chk_done_ready: assert property (done_out |-> instr_ready_out)
		else $error("done without ready");
	chk_load_read: assert property (s_take(acd_pkg::OP_LOAD) |=> mem_req_out.rd
		&& mem_req_out.addr == $past(instr_in[12:0])) else $error("load read missing");
	chk_store_write: assert property (s_take(acd_pkg::OP_STORE) |=> s_write_acc)
		else $error("store write wrong");
	chk_mpy_clear: assert property (s_take(acd_pkg::OP_MPY) |-> ##[1:6] !overflow_out)
		else $error("multiply left overflow set");
	chk_short_time: assert property (done_out && short_op |-> cnt == 16'(2 * WORD_CYCLES))
		else $error("short instruction time wrong");
	chk_idle_quiet: assert property (take && instr_in == acd_pkg::RC_IDLE |=>
		(!mem_req_out.rd && !mem_req_out.wr && $stable(acc_out) && $stable(aux_out)) [*3])
		else $error("idle instruction changed state");
	chk_ce_freeze: assert property (!ce_in |=> $stable(acc_out) && $stable(overflow_out))
		else $error("state moved while disabled");
endmodule : acd_checker

bind acd_datapath acd_checker #(.WORD_CYCLES(WORD_CYCLES)) u_acd_checker (
	.ref_clk_in(ref_clk_in), .reset_in(reset_in), .ce_in(ce_in),
	.instr_valid_in(instr_valid_in), .instr_in(instr_in), .instr_ready_out(instr_ready_out),
	.done_out(done_out), .mem_req_out(mem_req_out), .acc_out(acc_out), .aux_out(aux_out),
	.overflow_out(overflow_out));

/* File: acd_core_mem.sv */
// Core storage model that returns read data one cycle after the request.
`timescale 1ns/1ps
module acd_core_mem (
	input wire logic ref_clk_in,
	input wire acd_pkg::acd_mem_req_s mem_req_in,
	output logic [19:0] mem_rdata_out
);
	logic [19:0] m [0:8191];
	always @(posedge ref_clk_in) begin
		if (mem_req_in.wr) m[mem_req_in.addr] <= mem_req_in.wdata;
		if (mem_req_in.rd) mem_rdata_out <= m[mem_req_in.addr];
		else mem_rdata_out <= ~mem_rdata_out;
	end
endmodule : acd_core_mem

/* File: accumulator_arith_datapath_bench.sv */
// Self-checking bench for the accumulator arithmetic datapath.
`timescale 1ns/1ps
module accumulator_arith_datapath_bench;
	localparam int WC = 4;
	typedef struct packed {
		logic [19:0] acc;
		logic [19:0] aux;
		logic ovf;
		logic regs;
		logic [19:0] n;
	} acd_note_s;
	logic ref_clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic ce_in = 1'b1;
	logic instr_valid_in = 1'b0;
	logic [19:0] instr_in = 20'h00000;
	logic ovf_clear_in = 1'b0;
	logic [19:0] mem_rdata_in;
	logic instr_ready_out;
	logic done_out;
	acd_pkg::acd_mem_req_s mem_req_out;
	logic [19:0] acc_out;
	logic [19:0] aux_out;
	logic overflow_out;
	logic [19:0] m_acc = 20'h00000;
	logic [19:0] m_aux = 20'h00000;
	logic m_ovf = 1'b0;
	logic [19:0] w;
	logic [19:0] cyc = 20'h00000;
	logic [19:0] t_acc = 20'h00000;
	int mismatches = 0;
	int checks_done = 0;
	acd_note_s notes[$];
	logic [19:0] codes [14] = '{acd_pkg::RC_IDLE, acd_pkg::RC_INCREMENT, acd_pkg::RC_NEGATE,
		acd_pkg::RC_ACC_TO_AUX, acd_pkg::RC_DECREMENT, acd_pkg::RC_INVERT, acd_pkg::RC_SWAP,
		acd_pkg::RC_AUX_TO_ACC, acd_pkg::RC_MOVE_CLEAR, acd_pkg::RC_DECREMENT,
		acd_pkg::RC_PLUS_ONE, acd_pkg::RC_ALL_ONES, acd_pkg::RC_ZERO, acd_pkg::RC_CHANGE_SIGN};
	acd_datapath #(.WORD_CYCLES(WC)) dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.ce_in(ce_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
		.ovf_clear_in(ovf_clear_in), .mem_rdata_in(mem_rdata_in),
		.instr_ready_out(instr_ready_out), .done_out(done_out), .mem_req_out(mem_req_out),
		.acc_out(acc_out), .aux_out(aux_out), .overflow_out(overflow_out));
	acd_core_mem cm (.ref_clk_in(ref_clk_in), .mem_req_in(mem_req_out),
		.mem_rdata_out(mem_rdata_in));
	initial forever #25 ref_clk_in = ~ref_clk_in;
	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	function automatic logic [19:0] mi(input logic [4:0] o, input logic [12:0] y);
		return {o, 2'b00, y};
	endfunction : mi
	function automatic void apply(input logic [19:0] c);
		logic [19:0] t;
		t = m_acc;
		case (c)
			acd_pkg::RC_AUX_TO_ACC: m_acc = m_aux;
			acd_pkg::RC_ACC_TO_AUX: m_aux = t;
			acd_pkg::RC_SWAP: {m_acc, m_aux} = {m_aux, t};
			acd_pkg::RC_MOVE_CLEAR: {m_acc, m_aux} = {20'h00000, t};
			acd_pkg::RC_ZERO: m_acc = 20'h00000;
			acd_pkg::RC_PLUS_ONE: m_acc = 20'h00001;
			acd_pkg::RC_ALL_ONES: m_acc = 20'hFFFFF;
			acd_pkg::RC_INCREMENT: {m_acc, m_ovf} = {t + 20'h00001, m_ovf | (t == 20'h7FFFF)};
			acd_pkg::RC_DECREMENT: {m_acc, m_ovf} = {t - 20'h00001, m_ovf | (t == 20'h80000)};
			acd_pkg::RC_INVERT: m_acc = ~t;
			acd_pkg::RC_NEGATE: {m_acc, m_ovf} = {-t, m_ovf | (t == 20'h80000)};
			acd_pkg::RC_CHANGE_SIGN: m_acc = t ^ 20'h80000;
			default: ;
		endcase
	endfunction : apply
	task automatic issue(input logic [19:0] ins, input int n, input logic regs);
		int k;
		logic rdy;
		notes.push_back('{m_acc, m_aux, m_ovf, regs, 20'(n * WC)});
		instr_in = ins;
		instr_valid_in = 1'b1;
		k = 0;
		do begin
			rdy = instr_ready_out;
			@(posedge ref_clk_in);
			#1 k++;
		end while (rdy !== 1'b1 && k < 100);
		if (rdy !== 1'b1) begin
			mismatches++;
			complete_run();
		end
		t_acc = cyc;
		instr_valid_in = 1'b0;
		k = 0;
		while (done_out !== 1'b1 && k < 2000) begin
			@(posedge ref_clk_in);
			#1 k++;
		end
		if (k >= 2000) begin
			mismatches++;
			complete_run();
		end
	endtask : issue
	task automatic ld(input logic [12:0] y, input logic [19:0] v);
		cm.m[y] = v;
		m_acc = v;
		issue(mi(acd_pkg::OP_LOAD, y), 2, 1'b1);
	endtask : ld
	task automatic clr;
		ovf_clear_in = 1'b1;
		@(posedge ref_clk_in);
		#1 ovf_clear_in = 1'b0;
		m_ovf = 1'b0;
	endtask : clr
	always @(posedge ref_clk_in) begin : monitor
		acd_note_s e;
		cyc++;
		if (done_out === 1'b1) begin
			e = notes.pop_front();
			check(cyc - t_acc - 20'h00001, e.n);
			if (e.regs) begin
				check(acc_out, e.acc);
				check(aux_out, e.aux);
				check(20'(overflow_out), 20'(e.ovf));
			end
		end
	end
	initial begin
		void'($urandom(98550));
		repeat (2) @(posedge ref_clk_in);
		#1 reset_in = 1'b0;
		w = 20'($urandom);
		ld(13'h0100, w);
		issue(mi(acd_pkg::OP_STORE, 13'h0105), 2, 1'b1);
		check(cm.m[13'h0105], w);
		@(posedge ref_clk_in);
		#1 ce_in = 1'b0;
		repeat (3) @(posedge ref_clk_in);
		#1 ce_in = 1'b1;
		for (int r = 0; r < 3; r++) begin
			clr();
			ld(13'h0110, r == 0 ? 20'h7FFFF : r == 1 ? 20'h80000 : 20'($urandom));
			foreach (codes[i]) begin
				apply(codes[i]);
				issue(codes[i], 2, 1'b1);
			end
		end
		clr();
		cm.m[13'h0120] = 20'h00001;
		ld(13'h0121, 20'h7FFFF);
		{m_acc, m_ovf} = {20'h80000, 1'b1};
		issue(mi(acd_pkg::OP_ADD, 13'h0120), 2, 1'b1);
		ld(13'h0122, 20'h00003);
		apply(acd_pkg::RC_ACC_TO_AUX);
		issue(acd_pkg::RC_ACC_TO_AUX, 2, 1'b1);
		cm.m[13'h0123] = 20'h00005;
		ld(13'h0124, 20'h00001);
		{m_acc, m_aux, m_ovf} = {20'h00000, 20'h00010, 1'b0};
		issue(mi(acd_pkg::OP_MPY, 13'h0123), 13, 1'b1);
		w = 20'($urandom) & 20'h3FFFF;
		cm.m[13'h0125] = w;
		ld(13'h0126, 20'h20000);
		m_acc = 20'h20000 - w;
		issue(mi(acd_pkg::OP_SUB, 13'h0125), 2, 1'b1);
		cm.m[13'h0127] = 20'hABCDE;
		issue(mi(acd_pkg::OP_STADDR, 13'h0127), 2, 1'b1);
		check(cm.m[13'h0127], 20'hAA000 | (m_acc & 20'h01FFF));
		{cm.m[13'h0200], cm.m[13'h0201]} = {20'h00000, 20'h80001};
		{m_acc, m_aux} = {20'h00000, 20'h80001};
		issue(mi(acd_pkg::OP_DLOAD, 13'h0200), 3, 1'b1);
		{cm.m[13'h0210], cm.m[13'h0211]} = {20'h00000, 20'h80002};
		m_aux = 20'h00003;
		issue(mi(acd_pkg::OP_DADD, 13'h0210), 3, 1'b1);
		{cm.m[13'h0212], cm.m[13'h0213]} = {20'h00000, 20'h00001};
		m_aux = 20'h00002;
		issue(mi(acd_pkg::OP_DSUB, 13'h0212), 3, 1'b1);
		issue(mi(acd_pkg::OP_DSTORE, 13'h0300), 3, 1'b1);
		check(cm.m[13'h0301], m_aux);
		cm.m[13'h0304] = 20'h12345;
		issue(mi(acd_pkg::OP_DSTORE, 13'h0305), 3, 1'b1);
		check(cm.m[13'h0305] ^ cm.m[13'h0304], m_aux ^ 20'h12345);
		cm.m[13'h0401] = 20'h00005;
		ld(13'h0402, 20'h00005);
		m_ovf = 1'b1;
		issue(mi(acd_pkg::OP_DIV, 13'h0401), 2, 1'b1);
		ld(13'h0400, 20'h00011);
		apply(acd_pkg::RC_MOVE_CLEAR);
		issue(acd_pkg::RC_MOVE_CLEAR, 2, 1'b1);
		{m_acc, m_aux, m_ovf} = {20'h00003, 20'h00002, 1'b0};
		issue(mi(acd_pkg::OP_DIV, 13'h0401), 25, 1'b1);
		apply(acd_pkg::RC_ALL_ONES);
		issue(acd_pkg::RC_ALL_ONES, 2, 1'b1);
		{m_acc, m_aux, m_ovf} = {20'hE6667, 20'hFFFFF, 1'b0};
		issue(mi(acd_pkg::OP_DIV, 13'h0401), 28, 1'b1);
		repeat (3) @(posedge ref_clk_in);
		check(20'(notes.size()), 20'h00000);
		complete_run();
	end
endmodule : accumulator_arith_datapath_bench
